// >>> logic/arc_ctrl.sv
// Overview of operation
// - Modes are automatic, non-automatic with optional blocking, and live-line.
// - Live-line keeps reclosing out and drops per-trip blocking; lockout, manual close and maintenance blocking still apply.
// - Function stays disabled with no mode until enabled in configuration.
// - Command source picks auto or non-auto from the command bit only.
// - Input source: auto while auto input high, non-auto while low.
// - User source: command while remote high, else as input source.
// - Pulse source with remote high toggles mode on auto input fall.
// - Live-work input high forces live-line mode over every mode source once enabled.
// - Auto, remote and live-work inputs are delayed 100 ms.
// - Switching to remote keeps the previous mode until remotely changed.
// - Each stage initiates main, sensitive, or nothing per its setting.
// - External trip and start initiate when external setting selects main.
// - Starts initiate only with sequence coordination; trips always may.
// - Initiation needs auto, no live-line, shots left, no lockout, in service.
// - Per-trip settings block instantaneous main and sensitive stages.
// - Penultimate maintenance count blocks instantaneous if setting selects.
// - Optional blocking when locked out, after manual close, in non-auto.
// - Immediate sync reclose closes during dead time when live and in sync.
// - Otherwise dead timer advances only while dead enable is high.
// - Unconnected dead enable counts as high.
// - Auto close after dead time or sync, gated by healthy and checks.
// - Auto close request goes out to breaker control.
// - Sequence counter increments per reclose initiation, clears at cycle end.
`default_nettype none
module arc_ctrl #(
  parameter int TICK_CYCLES = arc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  // Register bus
  input wire arc_pkg::apb_req_t APB_REQ_IN,
  output arc_pkg::apb_rsp_t APB_RSP_OUT,
  // Field inputs from pins
  input wire arc_pkg::pins_t PINS_IN,
  // Protection stage starts and trips, same clock
  input wire arc_pkg::prot_t PROT_IN,
  // Mode indication
  output logic AUTO_MODE_OUT,
  output logic NON_AUTO_MODE_OUT,
  output logic LIVE_LINE_MODE_OUT,
  // Cycle indication
  output logic RECLOSE_INITIATE_OUT,
  output logic DEAD_TIME_RUNNING_OUT,
  output logic [2:0] SEQ_COUNT_OUT,
  // Breaker control and protection blocking
  output logic AUTO_CLOSE_OUT,
  output logic BLOCK_MAIN_INST_OUT,
  output logic BLOCK_SENS_INST_OUT
);

  typedef struct packed {
    arc_pkg::pins_t s1;
    arc_pkg::pins_t s2;
    logic [2:0][6:0] dly_cnt;
    logic [2:0] dly_val;
    logic auto_prev;
    logic [15:0] tick_cnt;
    arc_pkg::ctrl_t ctrl;
    logic [15:0] stage_init;
    logic [15:0] trip_block;
    logic [7:0] shots;
    logic [15:0] dead_time;
    logic [31:0] rdata;
    arc_pkg::op_mode_t mode;
    logic held_auto;
    arc_pkg::cyc_state_t cyc;
    logic [2:0] seq_cnt;
    logic [15:0] dead_cnt;
    logic want_prev;
    logic initiate;
    logic auto_close;
    logic block_main;
    logic block_sens;
  } state_t;

  state_t q;
  state_t n;

  localparam int SHOT_MAIN_LSB_W = arc_pkg::SHOT_MAIN_LSB;

  logic tick;
  logic [2:0] raw;
  logic auto_f;
  logic rem_f;
  logic live_f;
  logic auto_fall;
  logic sel;
  logic cmd_written;
  logic wr;
  logic hit;
  logic [31:0] rd;
  arc_pkg::status_t st;
  arc_pkg::stage_action_t act;
  logic main_trip;
  logic main_start;
  logic sens_trip;
  logic sens_start;
  logic main_init;
  logic sens_init;
  logic qualify;
  logic want;
  logic init_ev;
  logic dead_en;
  logic [2:0] idx;
  logic pt_main;
  logic pt_sens;
  logic common_blk;

  always_comb begin
    n = q;
    tick = 1'b0;
    raw = '0;
    auto_f = 1'b0;
    rem_f = 1'b0;
    live_f = 1'b0;
    auto_fall = 1'b0;
    sel = 1'b0;
    cmd_written = 1'b0;
    wr = 1'b0;
    hit = 1'b0;
    rd = '0;
    st = '0;
    act = arc_pkg::ACT_NONE;
    main_trip = 1'b0;
    main_start = 1'b0;
    sens_trip = 1'b0;
    sens_start = 1'b0;
    main_init = 1'b0;
    sens_init = 1'b0;
    qualify = 1'b0;
    want = 1'b0;
    init_ev = 1'b0;
    dead_en = 1'b0;
    idx = '0;
    pt_main = 1'b0;
    pt_sens = 1'b0;
    common_blk = 1'b0;

    // Pin synchronisers
    n.s1 = PINS_IN;
    n.s2 = q.s1;

    // Millisecond tick
    tick = (q.tick_cnt == 16'(TICK_CYCLES - 1));
    n.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;

    // Transitions take effect after standing for the full delay
    raw = {q.s2.live_work_force_input, q.s2.remote_control,
           q.s2.auto_select_input};
    for (int i = 0; i < 3; i++) begin
      if (raw[i] == q.dly_val[i]) begin
        n.dly_cnt[i] = 7'h00;
      end else if (tick) begin
        if (q.dly_cnt[i] == 7'(arc_pkg::INPUT_DELAY_TICKS - 1)) begin
          n.dly_val[i] = raw[i];
          n.dly_cnt[i] = 7'h00;
        end else begin
          n.dly_cnt[i] = q.dly_cnt[i] + 7'h01;
        end
      end
    end
    auto_f = q.dly_val[0];
    rem_f = q.dly_val[1];
    live_f = q.dly_val[2];
    auto_fall = q.auto_prev & ~auto_f;
    n.auto_prev = auto_f;

    // Register bus
    hit = (APB_REQ_IN.paddr == arc_pkg::OFS_CTRL) ||
          (APB_REQ_IN.paddr == arc_pkg::OFS_STAGE_INIT) ||
          (APB_REQ_IN.paddr == arc_pkg::OFS_TRIP_BLOCK) ||
          (APB_REQ_IN.paddr == arc_pkg::OFS_SHOTS) ||
          (APB_REQ_IN.paddr == arc_pkg::OFS_DEAD_TIME) ||
          (APB_REQ_IN.paddr == arc_pkg::OFS_STATUS);
    wr = APB_REQ_IN.psel & APB_REQ_IN.penable & APB_REQ_IN.pwrite;
    if (wr) begin
      case (APB_REQ_IN.paddr)
        arc_pkg::OFS_CTRL: begin
          n.ctrl = arc_pkg::ctrl_t'(APB_REQ_IN.pwdata);
          n.ctrl.rsvd = '0;
          cmd_written = 1'b1;
        end
        arc_pkg::OFS_STAGE_INIT: begin
          n.stage_init = APB_REQ_IN.pwdata[15:0];
        end
        arc_pkg::OFS_TRIP_BLOCK: begin
          n.trip_block = APB_REQ_IN.pwdata[15:0] & 16'h1f1f;
        end
        arc_pkg::OFS_SHOTS: begin
          n.shots = APB_REQ_IN.pwdata[7:0] & 8'h77;
        end
        arc_pkg::OFS_DEAD_TIME: begin
          n.dead_time = APB_REQ_IN.pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    st.block_sens = q.block_sens;
    st.block_main = q.block_main;
    st.auto_close = q.auto_close;
    st.dead_running = DEAD_TIME_RUNNING_OUT;
    st.cycle = q.cyc;
    st.seq_count = q.seq_cnt;
    st.mode = q.mode;
    case (APB_REQ_IN.paddr)
      arc_pkg::OFS_CTRL: rd = q.ctrl;
      arc_pkg::OFS_STAGE_INIT: rd = {16'h0000, q.stage_init};
      arc_pkg::OFS_TRIP_BLOCK: rd = {16'h0000, q.trip_block};
      arc_pkg::OFS_SHOTS: rd = {24'h000000, q.shots};
      arc_pkg::OFS_DEAD_TIME: rd = {16'h0000, q.dead_time};
      arc_pkg::OFS_STATUS: rd = st;
      default: rd = 32'h0000_0000;
    endcase
    if (APB_REQ_IN.psel & ~APB_REQ_IN.penable) begin
      n.rdata = APB_REQ_IN.pwrite ? 32'h0000_0000 : rd;
    end

    // Mode selection
    sel = q.held_auto;
    case (q.ctrl.mode_source_setting)
      arc_pkg::SRC_COMMAND: sel = q.ctrl.cmd_auto;
      arc_pkg::SRC_INPUT: sel = auto_f;
      arc_pkg::SRC_USER: begin
        if (!rem_f) begin
          sel = auto_f;
        end else if (cmd_written) begin
          sel = n.ctrl.cmd_auto;
        end
      end
      arc_pkg::SRC_PULSE: begin
        if (!rem_f) begin
          sel = auto_f;
        end else if (auto_fall) begin
          sel = ~q.held_auto;
        end
      end
      default: sel = q.held_auto;
    endcase
    n.held_auto = sel;
    if (!q.ctrl.enable) begin
      n.mode = arc_pkg::MODE_OFF;
    end else if (live_f) begin
      n.mode = arc_pkg::MODE_LIVE;
    end else begin
      n.mode = sel ? arc_pkg::MODE_AUTO : arc_pkg::MODE_NON_AUTO;
    end

    // Initiation
    for (int i = 0; i < arc_pkg::STAGES; i++) begin
      act = arc_pkg::stage_action_t'(q.stage_init[2*i +: 2]);
      if (act == arc_pkg::ACT_MAIN) begin
        main_trip = main_trip | PROT_IN.trip[i];
        main_start = main_start | PROT_IN.start[i];
      end else if (act == arc_pkg::ACT_SENS) begin
        sens_trip = sens_trip | PROT_IN.trip[i];
        sens_start = sens_start | PROT_IN.start[i];
      end
    end
    if (q.ctrl.ext_prot_init) begin
      main_trip = main_trip | q.s2.external_trip_input;
      main_start = main_start | q.s2.external_start_input;
    end
    main_init = main_trip | (q.ctrl.seq_coord & main_start);
    sens_init = sens_trip | (q.ctrl.seq_coord & sens_start);
    qualify = (q.mode == arc_pkg::MODE_AUTO) & ~live_f &
              ~q.s2.breaker_operations_lockout &
              q.s2.breaker_in_service;
    want = qualify &
           ((main_init & (q.seq_cnt < q.shots[SHOT_MAIN_LSB_W +: 3])) |
            (sens_init & (q.seq_cnt < q.shots[arc_pkg::SHOT_SENS_LSB +: 3])));
    init_ev = want & ~q.want_prev;
    n.want_prev = want;

    // Reclose cycle
    dead_en = q.ctrl.dead_mapped ? q.s2.dead_interval_enable : 1'b1;
    n.initiate = 1'b0;
    case (q.cyc)
      arc_pkg::CYC_IDLE, arc_pkg::CYC_CLOSED: begin
        if (init_ev) begin
          n.cyc = arc_pkg::CYC_DEAD;
          n.initiate = 1'b1;
          n.dead_cnt = 16'h0000;
          if (q.seq_cnt != 3'h7) begin
            n.seq_cnt = q.seq_cnt + 3'h1;
          end
        end else if (q.cyc == arc_pkg::CYC_CLOSED && q.s2.cycle_end) begin
          n.cyc = arc_pkg::CYC_IDLE;
          n.seq_cnt = 3'h0;
        end
      end
      arc_pkg::CYC_DEAD: begin
        if (q.ctrl.immediate_sync_reclose && q.s2.sync_ok) begin
          n.cyc = arc_pkg::CYC_CLOSING;
        end else if (q.dead_cnt >= q.dead_time) begin
          n.cyc = arc_pkg::CYC_CLOSING;
        end else if (tick && dead_en) begin
          n.dead_cnt = q.dead_cnt + 16'h0001;
        end
      end
      arc_pkg::CYC_CLOSING: begin
        if (q.s2.breaker_closed) begin
          n.cyc = arc_pkg::CYC_CLOSED;
        end
      end
      default: n.cyc = arc_pkg::CYC_IDLE;
    endcase
    if (q.mode != arc_pkg::MODE_AUTO) begin
      n.cyc = arc_pkg::CYC_IDLE;
      n.seq_cnt = 3'h0;
      n.initiate = 1'b0;
    end
    n.auto_close = (q.cyc == arc_pkg::CYC_CLOSING) &
                   (q.mode == arc_pkg::MODE_AUTO) &
                   q.s2.breaker_healthy_input &
                   q.s2.system_checks_ok & ~q.s2.breaker_closed;

    // Instantaneous protection blocking
    idx = (q.seq_cnt > 3'(arc_pkg::TRIPS - 1)) ?
          3'(arc_pkg::TRIPS - 1) : q.seq_cnt;
    if (q.mode == arc_pkg::MODE_AUTO) begin
      pt_main = q.trip_block[idx];
      pt_sens = q.trip_block[arc_pkg::TRIP_SENS_LSB + int'(idx)];
    end
    common_blk = (q.s2.maint_penultimate &
                  q.ctrl.fault_frequency_block_setting) |
                 (q.s2.locked_out & q.ctrl.lockout_block) |
                 (q.s2.manual_close & q.ctrl.manual_block) |
                 ((q.mode == arc_pkg::MODE_NON_AUTO) &
                  q.ctrl.deselected_block_setting);
    n.block_main = pt_main | common_blk;
    n.block_sens = pt_sens | common_blk;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      q <= '0;
      q.ctrl <= arc_pkg::ctrl_t'(arc_pkg::CTRL_RST);
      q.stage_init <= arc_pkg::STAGE_INIT_RST;
      q.trip_block <= arc_pkg::TRIP_BLOCK_RST;
      q.shots <= arc_pkg::SHOTS_RST;
      q.dead_time <= arc_pkg::DEAD_TIME_RST;
    end else begin
      q <= n;
    end
  end

  // Zero-wait slave: read data is captured in the setup cycle
  assign APB_RSP_OUT.prdata = q.rdata;
  assign APB_RSP_OUT.pready = APB_REQ_IN.psel & APB_REQ_IN.penable;
  assign APB_RSP_OUT.pslverr = APB_REQ_IN.psel & APB_REQ_IN.penable & ~hit;

  assign AUTO_MODE_OUT = (q.mode == arc_pkg::MODE_AUTO);
  assign NON_AUTO_MODE_OUT = (q.mode == arc_pkg::MODE_NON_AUTO);
  assign LIVE_LINE_MODE_OUT = (q.mode == arc_pkg::MODE_LIVE);
  assign RECLOSE_INITIATE_OUT = q.initiate;
  assign DEAD_TIME_RUNNING_OUT = (q.cyc == arc_pkg::CYC_DEAD) &
                                 (q.ctrl.dead_mapped ?
                                  q.s2.dead_interval_enable : 1'b1);
  assign SEQ_COUNT_OUT = q.seq_cnt;
  assign AUTO_CLOSE_OUT = q.auto_close;
  assign BLOCK_MAIN_INST_OUT = q.block_main;
  assign BLOCK_SENS_INST_OUT = q.block_sens;

endmodule : arc_ctrl
`default_nettype wire

// >>> logic/arc_fix.sv
`default_nettype none
`default_nettype wire

// >>> logic/arc_pkg.sv
`default_nettype none
package arc_pkg;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int INPUT_DELAY_MS = 100;
  localparam int INPUT_DELAY_TICKS = INPUT_DELAY_MS / TICK_MS;

  // Sizes
  localparam int STAGES = 8;
  localparam int TRIPS = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAGE_INIT = 8'h04;
  localparam logic [7:0] OFS_TRIP_BLOCK = 8'h08;
  localparam logic [7:0] OFS_SHOTS = 8'h0c;
  localparam logic [7:0] OFS_DEAD_TIME = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Field positions outside the structs
  localparam int TRIP_SENS_LSB = 8;
  localparam int SHOT_MAIN_LSB = 0;
  localparam int SHOT_SENS_LSB = 4;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] STAGE_INIT_RST = 16'h0000;
  localparam logic [15:0] TRIP_BLOCK_RST = 16'h0000;
  localparam logic [7:0] SHOTS_RST = 8'h11;
  localparam logic [15:0] DEAD_TIME_RST = 16'h01f4;

  typedef enum logic [1:0] {
    SRC_COMMAND = 2'b00,
    SRC_INPUT = 2'b01,
    SRC_USER = 2'b10,
    SRC_PULSE = 2'b11
  } mode_src_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_NON_AUTO = 2'b10,
    MODE_LIVE = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_DEAD = 2'b01,
    CYC_CLOSING = 2'b10,
    CYC_CLOSED = 2'b11
  } cyc_state_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_MAIN = 2'b01,
    ACT_SENS = 2'b10,
    ACT_SPARE = 2'b11
  } stage_action_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic cmd_auto;
    logic dead_mapped;
    logic manual_block;
    logic lockout_block;
    logic fault_frequency_block_setting;
    logic immediate_sync_reclose;
    logic seq_coord;
    logic ext_prot_init;
    logic deselected_block_setting;
    mode_src_t mode_source_setting;
    logic enable;
  } ctrl_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic block_sens;
    logic block_main;
    logic auto_close;
    logic dead_running;
    cyc_state_t cycle;
    logic [2:0] seq_count;
    op_mode_t mode;
  } status_t;

  typedef struct packed {
    logic auto_select_input;
    logic remote_control;
    logic live_work_force_input;
    logic external_trip_input;
    logic external_start_input;
    logic dead_interval_enable;
    logic breaker_healthy_input;
    logic breaker_in_service;
    logic breaker_operations_lockout;
    logic maint_penultimate;
    logic locked_out;
    logic manual_close;
    logic sync_ok;
    logic system_checks_ok;
    logic breaker_closed;
    logic cycle_end;
  } pins_t;

  typedef struct packed {
    logic [STAGES-1:0] start;
    logic [STAGES-1:0] trip;
  } prot_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage : arc_pkg
`default_nettype wire

// >>> tb/arc_breaker_model.sv
`default_nettype none
module arc_breaker_model #(
  parameter int DELAY = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic close_req_in,
  input wire logic open_in,
  output logic closed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Breaker starts closed; closes again DELAY+1 cycles into a close request
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      closed_out <= 1'b1;
    end else if (open_in) begin
      cnt <= 0;
      closed_out <= 1'b0;
    end else if (close_req_in && !closed_out) begin
      cnt <= cnt + 1;
      if (cnt == DELAY) closed_out <= 1'b1;
    end
  end
endmodule : arc_breaker_model
`default_nettype wire

// >>> tb/arc_ctrl_assertions.sv
`default_nettype none
module arc_ctrl_checker (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire arc_pkg::apb_req_t APB_REQ_IN,
  input wire arc_pkg::apb_rsp_t APB_RSP_OUT,
  input wire logic AUTO_MODE_OUT,
  input wire logic NON_AUTO_MODE_OUT,
  input wire logic LIVE_LINE_MODE_OUT,
  input wire logic RECLOSE_INITIATE_OUT,
  input wire logic DEAD_TIME_RUNNING_OUT,
  input wire logic [2:0] SEQ_COUNT_OUT,
  input wire logic AUTO_CLOSE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic acc;
  assign acc = APB_REQ_IN.psel && APB_REQ_IN.penable;
  a_mode_onehot: assert property ($onehot0({AUTO_MODE_OUT,
    NON_AUTO_MODE_OUT, LIVE_LINE_MODE_OUT})) else $error("two modes");
  a_live_no_init: assert property (LIVE_LINE_MODE_OUT &&
    $past(LIVE_LINE_MODE_OUT) |-> !RECLOSE_INITIATE_OUT)
    else $error("initiation in live-line mode");
  a_off_at_start: assert property ($fell(RESET_IN) |->
    !(AUTO_MODE_OUT || NON_AUTO_MODE_OUT || LIVE_LINE_MODE_OUT))
    else $error("mode active before enable");
  a_pready_zero: assert property (acc |-> APB_RSP_OUT.pready)
    else $error("pready late");
  a_slverr_map: assert property (acc |-> APB_RSP_OUT.pslverr ==
    (APB_REQ_IN.paddr > 8'h14 || APB_REQ_IN.paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  a_init_single: assert property (RECLOSE_INITIATE_OUT |=>
    !RECLOSE_INITIATE_OUT) else $error("initiate pulse too long");
  a_init_auto: assert property (RECLOSE_INITIATE_OUT |->
    $past(AUTO_MODE_OUT)) else $error("initiation outside auto mode");
  a_init_count: assert property ($rose(RECLOSE_INITIATE_OUT) &&
    $past(SEQ_COUNT_OUT) != 3'h7 |-> SEQ_COUNT_OUT ==
    $past(SEQ_COUNT_OUT) + 3'h1) else $error("count not advanced");
  a_close_dead: assert property (AUTO_CLOSE_OUT |->
    !DEAD_TIME_RUNNING_OUT) else $error("close during dead time");
  c_init: cover property (RECLOSE_INITIATE_OUT);
  c_close: cover property ($rose(AUTO_CLOSE_OUT));
  c_live: cover property (LIVE_LINE_MODE_OUT);
endmodule : arc_ctrl_checker
bind arc_ctrl arc_ctrl_checker arc_ctrl_checker_i (
  .SYS_CLK_IN(SYS_CLK_IN),
  .RESET_IN(RESET_IN),
  .APB_REQ_IN(APB_REQ_IN),
  .APB_RSP_OUT(APB_RSP_OUT),
  .AUTO_MODE_OUT(AUTO_MODE_OUT),
  .NON_AUTO_MODE_OUT(NON_AUTO_MODE_OUT),
  .LIVE_LINE_MODE_OUT(LIVE_LINE_MODE_OUT),
  .RECLOSE_INITIATE_OUT(RECLOSE_INITIATE_OUT),
  .DEAD_TIME_RUNNING_OUT(DEAD_TIME_RUNNING_OUT),
  .SEQ_COUNT_OUT(SEQ_COUNT_OUT),
  .AUTO_CLOSE_OUT(AUTO_CLOSE_OUT)
);
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic open = 1'b0;
  logic closed;
  arc_pkg::apb_req_t req = '0;
  arc_pkg::apb_rsp_t rsp;
  arc_pkg::pins_t pins = '0;
  arc_pkg::prot_t prot = '0;
  logic auto_m, non_m, live_m, init, dead_run, aclose, blk_m, blk_s;
  logic [2:0] seq;
  logic [32:0] q_rd[$];
  logic [2:0] q_init[$];
  int fails = 0;
  int total_checks = 0;
  int s;
  always #50 clk = ~clk;
  arc_ctrl #(.TICK_CYCLES(10)) arc_ctrl_i (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .APB_REQ_IN(req),
    .APB_RSP_OUT(rsp), .PINS_IN(pins), .PROT_IN(prot),
    .AUTO_MODE_OUT(auto_m), .NON_AUTO_MODE_OUT(non_m),
    .LIVE_LINE_MODE_OUT(live_m), .RECLOSE_INITIATE_OUT(init),
    .DEAD_TIME_RUNNING_OUT(dead_run), .SEQ_COUNT_OUT(seq),
    .AUTO_CLOSE_OUT(aclose), .BLOCK_MAIN_INST_OUT(blk_m),
    .BLOCK_SENS_INST_OUT(blk_s)
  );
  arc_breaker_model #(.DELAY(4)) arc_breaker_model_i (
    .clk_in(clk), .rst_in(rst), .close_req_in(aclose),
    .open_in(open), .closed_out(closed)
  );
  always @(posedge clk) pins.breaker_closed <= closed;
  task automatic check(input string nm, input logic [32:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (req.psel && req.penable && rsp.pready && !req.pwrite)
      check("prdata", {rsp.pslverr, rsp.prdata}, q_rd.pop_front());
    if (init && q_init.size() == 0) check("initiate", 1'b1, 1'b0);
    else if (init) check("seq count", seq, q_init.pop_front());
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    if (!w) q_rd.push_back(e);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (!rsp.pready && n++ < 20);
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
    req <= '0;
  endtask : apb
  task automatic mode(input logic [2:0] e);
    check("mode", {auto_m, non_m, live_m}, e);
  endtask : mode
  task automatic wait_close(input logic v, input int b);
    int n;
    for (n = 0; n < b && aclose !== v; n++) @(posedge clk);
    if (n >= b) begin
      fails++;
      give_verdict();
    end
  endtask : wait_close
  task automatic trip(input bit ext);
    if (ext) pins.external_trip_input <= 1'b1;
    else prot.trip[s] <= 1'b1;
    open <= 1'b1;
    cyc(4);
    pins.external_trip_input <= 1'b0;
    prot.trip <= '0;
    open <= 1'b0;
  endtask : trip
  initial begin
    s = $urandom(32'h502e);
    s = $urandom % arc_pkg::STAGES;
    pins.breaker_in_service <= 1'b1;
    pins.breaker_healthy_input <= 1'b1;
    pins.system_checks_ok <= 1'b1;
    cyc(12);
    rst <= 1'b0;
    apb(0, arc_pkg::OFS_CTRL, 0, {1'b0, arc_pkg::CTRL_RST});
    apb(0, arc_pkg::OFS_SHOTS, 0, {25'h0, arc_pkg::SHOTS_RST});
    apb(0, arc_pkg::OFS_DEAD_TIME, 0, {17'h0, arc_pkg::DEAD_TIME_RST});
    apb(0, 8'h18, 0, {1'b1, 32'h0});
    apb(1, arc_pkg::OFS_STATUS, 32'hffff_ffff, 0);
    apb(0, arc_pkg::OFS_STATUS, 0, 33'h0);
    mode(3'b000);
    $display("registers done");
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0001, 0);
    cyc(3);
    mode(3'b010);
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_080b, 0);
    pins.auto_select_input <= 1'b1;
    cyc(500);
    mode(3'b010);
    check("deselected block", blk_m, 1'b1);
    cyc(600);
    mode(3'b100);
    check("auto no block", blk_m, 1'b0);
    pins.live_work_force_input <= 1'b1;
    cyc(1100);
    mode(3'b001);
    check("live block main", blk_m, 1'b0);
    check("live block sens", blk_s, 1'b0);
    pins.live_work_force_input <= 1'b0;
    pins.remote_control <= 1'b1;
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0007, 0);
    cyc(1100);
    mode(3'b100);
    pins.auto_select_input <= 1'b0;
    cyc(1100);
    mode(3'b010);
    pins.remote_control <= 1'b0;
    pins.auto_select_input <= 1'b1;
    cyc(1100);
    mode(3'b100);
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0005, 0);
    pins.remote_control <= 1'b1;
    cyc(1100);
    mode(3'b100);
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_000d, 0);
    cyc(3);
    mode(3'b010);
    check("non-auto block sens", blk_s, 1'b1);
    pins.remote_control <= 1'b0;
    cyc(1100);
    mode(3'b100);
    $display("modes done");
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0801, 0);
    apb(1, arc_pkg::OFS_STAGE_INIT, 32'h1 << (2 * s), 0);
    apb(1, arc_pkg::OFS_TRIP_BLOCK, 32'h0000_0002, 0);
    apb(1, arc_pkg::OFS_SHOTS, 32'h0000_0002, 0);
    apb(1, arc_pkg::OFS_DEAD_TIME, 32'h0000_0003, 0);
    prot.start[s] <= 1'b1;
    cyc(10);
    prot.start <= '0;
    q_init.push_back(3'h1);
    trip(0);
    cyc(2);
    check("block main", blk_m, 1'b1);
    check("dead running", dead_run, 1'b1);
    wait_close(1'b1, 200);
    wait_close(1'b0, 100);
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0811, 0);
    q_init.push_back(3'h2);
    trip(1);
    wait_close(1'b1, 200);
    wait_close(1'b0, 100);
    trip(0);
    cyc(50);
    check("seq limit", seq, 3'h2);
    pins.cycle_end <= 1'b1;
    cyc(6);
    pins.cycle_end <= 1'b0;
    check("seq clear", seq, 3'h0);
    apb(1, arc_pkg::OFS_DEAD_TIME, 32'h0000_ffff, 0);
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0841, 0);
    pins.sync_ok <= 1'b1;
    q_init.push_back(3'h1);
    trip(0);
    wait_close(1'b1, 30);
    pins.locked_out <= 1'b1;
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_0941, 0);
    cyc(4);
    check("lockout block", blk_s, 1'b1);
    pins.locked_out <= 1'b0;
    pins.maint_penultimate <= 1'b1;
    apb(1, arc_pkg::OFS_CTRL, 32'h0000_08c1, 0);
    cyc(4);
    check("maint block", blk_s, 1'b1);
    $display("cycles done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
